// ==== hdl/adcdc_cfg.svh ====
// register offsets, field positions, reset values and timing figures
`ifndef ADCDC_CFG_SVH
`define ADCDC_CFG_SVH

// register offsets on the serial configuration port
`define ADCDC_ADDR_THRESH     15'h003C
`define ADCDC_ADDR_CORR_MODE  15'h003D
`define ADCDC_ADDR_LANE_CFG   15'h0047

// reset values
`define ADCDC_RST_THRESH      8'h00
`define ADCDC_RST_CORR_MODE   8'h00
`define ADCDC_RST_LANE_CFG    8'h00

// dc offset correction mode fields
`define ADCDC_CORR_EN_BIT     0
`define ADCDC_DC_TC_LSB       1
`define ADCDC_DC_TC_MSB       2

// lane transmitter config fields
`define ADCDC_SER_DEM_LSB     0
`define ADCDC_SER_DEM_MSB     2
`define ADCDC_SER_VOD_LSB     4
`define ADCDC_SER_VOD_MSB     6

// over-range limit step per threshold unit, as a shift
`define ADCDC_LIMIT_STEP_SHIFT 7

// filter time constants in ns and the sampling clock in MHz
`define ADCDC_CLK_MHZ         40
`define ADCDC_TC0_NS          11000
`define ADCDC_TC1_NS          89000
`define ADCDC_TC2_NS          708000
`define ADCDC_TC3_NS          5700000

// serial frame layout
`define ADCDC_HDR_BITS        16
`define ADCDC_FRAME_BITS      24

`endif

// ==== hdl/adcdc_pkg.sv ====
// types shared by the configuration register block
package adcdc_pkg;
    typedef logic signed [15:0] adcdc_sample_t;
    typedef logic [7:0]         adcdc_byte_t;
    typedef logic [14:0]        adcdc_addr_t;
endpackage : adcdc_pkg

// ==== hdl/adcdc_regs_top.sv ====
// dc offset correction, over-range detection and lane config registers
// Behaviour
// - two-bit time constant picks filter bandwidth: 11 us up to 5.7 ms
// - correction applies only while enable bit is one; reset leaves it off
// - three-bit swing select picks lane output level, 0.580 V to 1.240 V
// - three-bit de-emphasis select, 0.0 dB at code 0 up to 6.8 dB
// - detection limits sit threshold times 128 codes inside full scale
// - over-range flag set when sample lies beyond either limit
// - zero threshold uses the full-scale codes themselves as limits
`timescale 1ns/100ps
`include "adcdc_cfg.svh"
module adcdc_regs_top (
    // clock and reset
    input  wire logic                   clock,
    input  wire logic                   rst_b,
    // serial configuration port
    input  wire logic                   spi_sclk,
    input  wire logic                   spi_cs_b,
    input  wire logic                   spi_sdi,
    output logic                        spi_sdo,
    output logic                        spi_sdo_oe,
    // converter data path
    input  wire adcdc_pkg::adcdc_sample_t sample_in,
    output adcdc_pkg::adcdc_sample_t    sample_out,
    output logic                        overrange_indicator,
    // configuration towards the analog and lane circuitry
    output logic                        offset_corr_enable,
    output logic [1:0]                  offset_filter_time_const,
    output logic [2:0]                  lane_swing_select,
    output logic [2:0]                  lane_deemphasis_select
);

    localparam int FRAC = 18;
    localparam int SH0  = $clog2(`ADCDC_TC0_NS * `ADCDC_CLK_MHZ / 1000);
    localparam int SH1  = $clog2(`ADCDC_TC1_NS * `ADCDC_CLK_MHZ / 1000);
    localparam int SH2  = $clog2(`ADCDC_TC2_NS * `ADCDC_CLK_MHZ / 1000);
    localparam int SH3  = $clog2(`ADCDC_TC3_NS * `ADCDC_CLK_MHZ / 1000);

    // register reset images, sliced into their fields below
    localparam logic [7:0] MODE_RST = `ADCDC_RST_CORR_MODE;
    localparam logic [7:0] LANE_RST = `ADCDC_RST_LANE_CFG;

    adcdc_pkg::adcdc_addr_t  reg_addr;
    adcdc_pkg::adcdc_byte_t  reg_wdata;
    adcdc_pkg::adcdc_byte_t  reg_rdata;
    logic                    reg_wr;

    logic [7:0]              thresh_q;
    logic                    en_q;
    logic [1:0]              tc_q;
    logic [2:0]              swing_q;
    logic [2:0]              dem_q;
    logic signed [35:0]      acc_q;
    logic signed [35:0]      acc_d;
    adcdc_pkg::adcdc_sample_t out_q;
    adcdc_pkg::adcdc_sample_t out_d;
    logic                    flag_q;

    // clamp a 17-bit difference into the 16-bit sample range
    function automatic adcdc_pkg::adcdc_sample_t sat16(input logic signed [16:0] v);
        if (v > 17'sh07FFF) begin
            return 16'sh7FFF;
        end else if (v < -17'sh08000) begin
            return 16'sh8000;
        end
        return v[15:0];
    endfunction : sat16

    ////////////////////////////////////////////////////////////////////////////
    // serial port slave
    adcdc_spi_port u_port (
        .clock      (clock),
        .rst_b      (rst_b),
        .spi_sclk   (spi_sclk),
        .spi_cs_b   (spi_cs_b),
        .spi_sdi    (spi_sdi),
        .spi_sdo    (spi_sdo),
        .spi_sdo_oe (spi_sdo_oe),
        .reg_addr   (reg_addr),
        .reg_wdata  (reg_wdata),
        .reg_wr     (reg_wr),
        .reg_rdata  (reg_rdata)
    );

    ////////////////////////////////////////////////////////////////////////////
    // register decode and read mux; reserved bits read as zero
    wire hit_th  = (reg_addr == `ADCDC_ADDR_THRESH);
    wire hit_dc  = (reg_addr == `ADCDC_ADDR_CORR_MODE);
    wire hit_ser = (reg_addr == `ADCDC_ADDR_LANE_CFG);

    assign reg_rdata = hit_th  ? thresh_q :
                       hit_dc  ? {5'h00, tc_q, en_q} :
                       hit_ser ? {1'b0, swing_q, 1'b0, dem_q} : 8'h00;

    // register writes; reserved positions are not stored
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            thresh_q <= `ADCDC_RST_THRESH;
            en_q     <= MODE_RST[`ADCDC_CORR_EN_BIT];
            tc_q     <= MODE_RST[`ADCDC_DC_TC_MSB:`ADCDC_DC_TC_LSB];
            swing_q  <= LANE_RST[`ADCDC_SER_VOD_MSB:`ADCDC_SER_VOD_LSB];
            dem_q    <= LANE_RST[`ADCDC_SER_DEM_MSB:`ADCDC_SER_DEM_LSB];
        end else if (reg_wr) begin
            if (hit_th) begin
                thresh_q <= reg_wdata;
            end
            if (hit_dc) begin
                en_q <= reg_wdata[`ADCDC_CORR_EN_BIT];
                tc_q <= reg_wdata[`ADCDC_DC_TC_MSB:`ADCDC_DC_TC_LSB];
            end
            if (hit_ser) begin
                swing_q <= reg_wdata[`ADCDC_SER_VOD_MSB:`ADCDC_SER_VOD_LSB];
                dem_q   <= reg_wdata[`ADCDC_SER_DEM_MSB:`ADCDC_SER_DEM_LSB];
            end
        end
    end

    assign offset_corr_enable       = en_q;
    assign offset_filter_time_const = tc_q;
    assign lane_swing_select        = swing_q;
    assign lane_deemphasis_select   = dem_q;

    ////////////////////////////////////////////////////////////////////////////
    // over-range limits and detection
    wire [15:0] th_span = 16'(thresh_q) << `ADCDC_LIMIT_STEP_SHIFT;
    wire signed [15:0] pos_lim = 16'sh7FFF - $signed(th_span);
    wire signed [15:0] neg_lim = 16'sh8000 + $signed(th_span);
    wire over_w = (sample_in > pos_lim) || (sample_in < neg_lim);

    ////////////////////////////////////////////////////////////////////////////
    // dc estimate: acc tracks the input with a shift-set time constant
    wire [4:0] dc_shift = (tc_q == 2'h0) ? 5'(SH0) :
                          (tc_q == 2'h1) ? 5'(SH1) :
                          (tc_q == 2'h2) ? 5'(SH2) : 5'(SH3);
    wire signed [35:0] x_ext = $signed({{2{sample_in[15]}}, sample_in, 18'h00000});
    wire signed [35:0] err   = x_ext - acc_q;
    wire signed [35:0] step  = err >>> dc_shift;
    wire signed [15:0] est   = acc_q[FRAC+15:FRAC];
    wire signed [16:0] corr  = {sample_in[15], sample_in} - {est[15], est};

    assign acc_d = en_q ? acc_q + step : 36'sh0;
    assign out_d = en_q ? sat16(corr) : sample_in;

    // data path flops
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            acc_q <= 36'sh0;
            out_q <= 16'sh0000;
            flag_q <= 1'b0;
        end else begin
            acc_q  <= acc_d;
            out_q  <= out_d;
            flag_q <= over_w;
        end
    end

    assign sample_out          = out_q;
    assign overrange_indicator = flag_q;

    ////////////////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_b);

    // filter shift per time-constant code
    tc_shift_map_a: assert property (
        dc_shift == 5'(9 + 3 * tc_q))
        else $error("time constant shift wrong");

    // a mode write lands on the enable and time-constant outputs
    mode_write_a: assert property (
        reg_wr && hit_dc |=> offset_corr_enable == $past(reg_wdata[`ADCDC_CORR_EN_BIT])
            && offset_filter_time_const == $past(reg_wdata[2:1]))
        else $error("correction mode not updated");

    // correction off passes samples straight through
    corr_off_pass_a: assert property (
        !en_q |=> sample_out == $past(sample_in))
        else $error("sample altered while correction off");

    // lane register writes reach the outputs
    swing_write_a: assert property (
        reg_wr && hit_ser |=> lane_swing_select == $past(reg_wdata[6:4]))
        else $error("swing select not updated");
    deemph_write_a: assert property (
        reg_wr && hit_ser |=> lane_deemphasis_select == $past(reg_wdata[2:0]))
        else $error("de-emphasis select not updated");

    // limits sit 128 codes per threshold unit inside full scale
    limit_span_a: assert property (
        int'(pos_lim) == 32767 - 128 * int'(thresh_q))
        else $error("positive limit wrong");
    neg_limit_a: assert property (
        int'(neg_lim) == -32768 + 128 * int'(thresh_q))
        else $error("negative limit wrong");

    // flag follows the raw sample against the limits
    flag_set_a: assert property (
        (sample_in > pos_lim) || (sample_in < neg_lim) |=> overrange_indicator)
        else $error("over-range not flagged");
    flag_clear_a: assert property (
        (sample_in <= pos_lim) && (sample_in >= neg_lim) |=> !overrange_indicator)
        else $error("over-range flagged inside limits");
    flag_fullscale_a: assert property (
        thresh_q == 8'h00 && $stable(thresh_q) |=> !overrange_indicator)
        else $error("flag at full-scale limits");

    // corrected output and idle estimate
    dc_subtract_a: assert property (
        en_q |=> sample_out == sat16(17'($past(sample_in)) - 17'($past(est))))
        else $error("corrected sample wrong");
    acc_idle_a: assert property (
        !en_q |=> acc_q == 36'sh0)
        else $error("dc estimate not cleared while off");

    // main scenarios
    cov_corr_on_c:  cover property (en_q && tc_q == 2'h3);
    cov_flag_c:     cover property (overrange_indicator && thresh_q != 8'h00);
    cov_read_c:     cover property (spi_sdo_oe);
    cov_mode_wr_c:  cover property (reg_wr && hit_dc);
    cov_lane_wr_c:  cover property (reg_wr && hit_ser);

endmodule : adcdc_regs_top

// ==== hdl/adcdc_spi_port.sv ====
// serial configuration port slave: pin synchronisers and frame shifter
`timescale 1ns/100ps
`include "adcdc_cfg.svh"
module adcdc_spi_port (
    // clock and reset
    input  wire logic                  clock,
    input  wire logic                  rst_b,
    // serial pins
    input  wire logic                  spi_sclk,
    input  wire logic                  spi_cs_b,
    input  wire logic                  spi_sdi,
    output logic                       spi_sdo,
    output logic                       spi_sdo_oe,
    // register side
    output adcdc_pkg::adcdc_addr_t     reg_addr,
    output adcdc_pkg::adcdc_byte_t     reg_wdata,
    output logic                       reg_wr,
    input  wire adcdc_pkg::adcdc_byte_t reg_rdata
);

    logic [2:0]              sync1_q;
    logic [2:0]              sync2_q;
    logic [2:0]              sync3_q;
    logic [2:0]              filt_q;
    logic [2:0]              filt_d;
    logic [4:0]              cnt_q;
    logic [23:0]             sr_q;
    logic                    rd_q;
    logic [7:0]              sdo_sr_q;
    adcdc_pkg::adcdc_addr_t  addr_q;
    adcdc_pkg::adcdc_byte_t  wdata_q;
    logic                    wr_q;

    // a pin change counts once the second and third stages agree
    assign filt_d = (sync2_q & ~(sync2_q ^ sync3_q)) | (filt_q & (sync2_q ^ sync3_q));

    wire active_w = ~filt_q[1];
    wire rise_w   = active_w & ~filt_q[0] & filt_d[0];
    wire fall_w   = active_w & filt_q[0] & ~filt_d[0];
    wire sdi_w    = filt_d[2];
    wire hdr_w    = rise_w & (cnt_q == 5'(`ADCDC_HDR_BITS - 1));
    wire last_w   = rise_w & (cnt_q == 5'(`ADCDC_FRAME_BITS - 1));
    wire more_w   = cnt_q < 5'(`ADCDC_FRAME_BITS);

    // three-stage pin synchronisers; reset matches the idle pins so no false edge follows
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            sync1_q <= 3'h2;
            sync2_q <= 3'h2;
            sync3_q <= 3'h2;
            filt_q  <= 3'h2;
        end else begin
            sync1_q <= {spi_sdi, spi_cs_b, spi_sclk};
            sync2_q <= sync1_q;
            sync3_q <= sync2_q;
            filt_q  <= filt_d;
        end
    end

    // frame shifter: one read/write bit, 15 address bits, 8 data bits
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            cnt_q    <= 5'h00;
            sr_q     <= 24'h000000;
            rd_q     <= 1'b0;
            addr_q   <= 15'h0000;
            wdata_q  <= 8'h00;
            wr_q     <= 1'b0;
            sdo_sr_q <= 8'h00;
        end else begin
            wr_q <= last_w & ~rd_q;
            if (!active_w) begin
                cnt_q <= 5'h00;
                rd_q  <= 1'b0;
            end else if (rise_w && more_w) begin
                sr_q  <= {sr_q[22:0], sdi_w};
                cnt_q <= cnt_q + 5'h01;
            end
            if (hdr_w) begin
                rd_q   <= sr_q[14];
                addr_q <= {sr_q[13:0], sdi_w};
            end
            if (last_w) begin
                wdata_q <= {sr_q[6:0], sdi_w};
            end
            if (fall_w && cnt_q == 5'(`ADCDC_HDR_BITS)) begin
                sdo_sr_q <= reg_rdata;
            end else if (fall_w && more_w) begin
                sdo_sr_q <= {sdo_sr_q[6:0], 1'b0};
            end
        end
    end

    assign spi_sdo    = sdo_sr_q[7];
    assign spi_sdo_oe = active_w & rd_q & (cnt_q >= 5'(`ADCDC_HDR_BITS));
    assign reg_addr   = addr_q;
    assign reg_wdata  = wdata_q;
    assign reg_wr     = wr_q;

endmodule : adcdc_spi_port

// ==== sim/adc_dc_offset_and_lane_cfg_regs_tb.sv ====
// self-checking bench for the offset correction and lane config registers
`timescale 1ns/100ps
module adc_dc_offset_and_lane_cfg_regs_tb;
    typedef struct {logic [14:0] addr; logic [7:0] data; logic [8:0] cfg;} adcdc_row_s;
    logic                    clock, rst_b, spi_sclk, spi_cs_b, spi_sdi, spi_sdo, spi_sdo_oe;
    adcdc_pkg::adcdc_sample_t sample_in, sample_out;
    logic                    overrange_indicator, offset_corr_enable;
    logic [1:0]              offset_filter_time_const;
    logic [2:0]              lane_swing_select, lane_deemphasis_select;
    logic [7:0]              rd;
    int                      n_errors, n_compared, cycles;
    adcdc_row_s              rows [14];

    adcdc_regs_top adcdc_regs_top_inst (.clock(clock), .rst_b(rst_b), .spi_sclk(spi_sclk),
        .spi_cs_b(spi_cs_b), .spi_sdi(spi_sdi), .spi_sdo(spi_sdo), .spi_sdo_oe(spi_sdo_oe),
        .sample_in(sample_in), .sample_out(sample_out),
        .overrange_indicator(overrange_indicator), .offset_corr_enable(offset_corr_enable),
        .offset_filter_time_const(offset_filter_time_const),
        .lane_swing_select(lane_swing_select), .lane_deemphasis_select(lane_deemphasis_select));

    ////////////////////////////////////////////////////////////////////////////////////////
    // clock, 25 ns period
    initial begin
        clock = 1'b0;
        forever #12.5 clock = ~clock;
    end

    // hang guard: well above the expected run of about 20000 cycles
    always @(posedge clock) begin
        cycles++;
        if (cycles == 40000) begin
            n_errors++;
            wrap_up();
        end
    end

    ////////////////////////////////////////////////////////////////////////////////////////
    task automatic wrap_up();
        $display("compared %0d, errors %0d", n_compared, n_errors);
        if (n_errors == 0 && n_compared > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : wrap_up

    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        n_compared++;
        if (got !== exp) begin
            n_errors++;
            $display("unexpected %s: expected %h seen %h", what, exp, got);
        end
    endtask : chk

    // one serial phase, longer than the four clocks the synchroniser needs
    task automatic half();
        repeat (6) @(negedge clock);
    endtask : half

    // serial frame of nbits bits; fewer than 24 aborts it mid-way
    task automatic frame(input logic r, input logic [14:0] a, input logic [7:0] d, input int nbits);
        logic [23:0] f;
        f = {r, a, d};
        rd = 8'h00;
        spi_cs_b = 1'b0;
        half();
        for (int i = 23; i >= 24 - nbits; i--) begin
            spi_sdi = f[i];
            half();
            if (i < 8) begin
                rd[i] = spi_sdo;
                chk("sdo_oe", r, spi_sdo_oe);
            end
            spi_sclk = 1'b1;
            half();
            spi_sclk = 1'b0;
        end
        half();
        spi_cs_b = 1'b1;
        spi_sdi = ~spi_sdi; // no pull on the data line once deselected
        repeat (12) @(negedge clock);
    endtask : frame

    // one sample in, pass-through value and over-range flag one cycle later
    task automatic samp(input logic [15:0] s, input logic exp_flag);
        sample_in = s;
        @(negedge clock);
        chk("sample_out", s, sample_out);
        chk("overrange", exp_flag, overrange_indicator);
    endtask : samp

    task automatic cfg_chk(input logic [8:0] e);
        chk("enable", e[8], offset_corr_enable);
        chk("time_const", e[7:6], offset_filter_time_const);
        chk("swing", e[5:3], lane_swing_select);
        chk("deemphasis", e[2:0], lane_deemphasis_select);
    endtask : cfg_chk

    ////////////////////////////////////////////////////////////////////////////////////////
    // main sequence
    initial begin
        rows = '{'{15'h003D, 8'h01, 9'h100}, '{15'h003D, 8'h03, 9'h140},
                 '{15'h003D, 8'h05, 9'h180}, '{15'h003D, 8'h07, 9'h1C0},
                 '{15'h003D, 8'h06, 9'h0C0}, '{15'h0047, 8'h11, 9'h0C9},
                 '{15'h0047, 8'h22, 9'h0D2}, '{15'h0047, 8'h33, 9'h0DB},
                 '{15'h0047, 8'h44, 9'h0E4}, '{15'h0047, 8'h55, 9'h0ED},
                 '{15'h0047, 8'h66, 9'h0F6}, '{15'h0047, 8'h77, 9'h0FF},
                 '{15'h0047, 8'h70, 9'h0F8}, '{15'h003D, 8'h00, 9'h038}};
        rst_b = 1'b0;
        spi_sclk = 1'b0;
        spi_cs_b = 1'b1;
        spi_sdi = 1'b1;
        sample_in = 16'h0000;
        repeat (16) @(negedge clock);
        rst_b = 1'b1;
        repeat (8) @(negedge clock);
        // reset values of outputs and registers
        cfg_chk(9'h000);
        frame(1'b1, 15'h003D, 8'h00, 24);
        chk("mode reset", 8'h00, rd);
        frame(1'b1, 15'h0047, 8'h00, 24);
        chk("lane reset", 8'h00, rd);
        // table rows: write, compare outputs, read back
        foreach (rows[k]) begin
            frame(1'b0, rows[k].addr, rows[k].data, 24);
            cfg_chk(rows[k].cfg);
            frame(1'b1, rows[k].addr, 8'h00, 24);
            chk("readback", rows[k].data, rd);
        end
        // aborted frame and unmapped address change nothing
        frame(1'b0, 15'h0047, 8'h00, 20);
        frame(1'b0, 15'h0050, 8'h5A, 24);
        frame(1'b1, 15'h0050, 8'h00, 24);
        chk("unmapped", 8'h00, rd);
        cfg_chk(9'h038);
        // over-range limits at default, 2, 255 and 128
        samp(16'h7FFF, 1'b0);
        samp(16'h8000, 1'b0);
        frame(1'b0, 15'h003C, 8'h02, 24);
        samp(16'h7EFF, 1'b0);
        samp(16'h7F00, 1'b1);
        samp(16'h8100, 1'b0);
        samp(16'h80FF, 1'b1);
        frame(1'b0, 15'h003C, 8'hFF, 24);
        frame(1'b1, 15'h003C, 8'h00, 24);
        chk("threshold", 8'hFF, rd);
        samp(16'h007F, 1'b0);
        samp(16'h0080, 1'b1);
        samp(16'hFF80, 1'b0);
        samp(16'hFF7F, 1'b1);
        frame(1'b0, 15'h003C, 8'h80, 24);
        samp(16'h3FFF, 1'b0);
        samp(16'h4000, 1'b1);
        samp(16'hC000, 1'b0);
        samp(16'hBFFF, 1'b1);
        // fastest filter: a step decays by about 1/e in 512 cycles
        sample_in = 16'h1000;
        frame(1'b0, 15'h003D, 8'h01, 24);
        repeat (490) @(negedge clock);
        chk("decay fast", 1, sample_out > 16'sd1000 && sample_out < 16'sd2000);
        repeat (6000) @(negedge clock);
        chk("settled", 1, sample_out > -16'sd8 && sample_out < 16'sd8);
        frame(1'b0, 15'h003D, 8'h00, 24);
        samp(16'h1000, 1'b0);
        // next filter step is eight times slower
        frame(1'b0, 15'h003D, 8'h03, 24);
        repeat (490) @(negedge clock);
        chk("decay slow", 1, sample_out > 16'sd3300 && sample_out < 16'sd3900);
        frame(1'b0, 15'h003D, 8'h00, 24);
        samp(16'h0123, 1'b0);
        // reset in mid-run returns every register to its default
        frame(1'b0, 15'h003D, 8'h07, 24);
        @(negedge clock);
        rst_b = 1'b0;
        repeat (2) @(negedge clock);
        cfg_chk(9'h000);
        rst_b = 1'b1;
        repeat (4) @(negedge clock);
        cfg_chk(9'h000);
        samp(16'h7FFF, 1'b0);
        frame(1'b1, 15'h003C, 8'h00, 24);
        chk("threshold reset", 8'h00, rd);
        wrap_up();
    end
endmodule : adc_dc_offset_and_lane_cfg_regs_tb
